// *** inc/rng_gate_cfg.svh ***
/*
 Timing counts, thresholds and widths for the random number health gate.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef RNG_GATE_CFG_SVH
`define RNG_GATE_CFG_SVH
`define RNG_STUCK_LIMIT 6'h20
`define RNG_WIN_BITS 8'h80
`define RNG_ONES_MIN 8'h28
`define RNG_ONES_MAX 8'h58
`define RNG_SEED_BITS 9'h100
// Arbitrary nonzero start state of the mixing register
`define RNG_DRG_INIT 32'h5EEDC0DE
`define RNG_STATE_W 32
`define RNG_BUF_DEPTH 2
`endif

// *** inc/rng_gate_pkg.sv ***
/*
 Types for the random number health gate.
 Assumes rng_gate_cfg.svh is on the include path.
*/
`include "rng_gate_cfg.svh"
package rng_gate_pkg;
   typedef enum logic [1:0] {
      ST_STARTUP = 2'b00,
      ST_SEEDING = 2'b01,
      ST_RUN = 2'b10,
      ST_FAILED = 2'b11
   } gate_state_t;
endpackage : rng_gate_pkg

// *** design/word_skid_buf.sv ***
/*
 Two-entry valid/ready buffer for random words.
 Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/10ps
module word_skid_buf (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic flush_i,
   input wire logic [15:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   output logic [15:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   logic [15:0] mem_ff [0:1];
   logic rd_ptr_ff;
   logic wr_ptr_ff;
   logic [1:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready_o = (cnt_ff != 2'h2);
   assign out_valid_o = (cnt_ff != 2'h0);
   assign out_data_o = mem_ff[rd_ptr_ff];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || flush_i) begin
         rd_ptr_ff <= 1'b0;
         wr_ptr_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : word_skid_buf

// *** design/rng_health_gate.sv ***
/*
 Random number gate: health tests on raw entropy bits, physical or hybrid
 word assembly, repeat test and a held-until-read output word.
 Assumes raw_bit_i/raw_valid_i are synchronous to clk_i and come from the
 analog source; restart_i re-runs the start-up sequence.
*/
`timescale 1ns/10ps
`include "rng_gate_cfg.svh"
module rng_health_gate (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic restart_i,
   input wire logic hybrid_generator_mode_i,
   input wire logic word16_i,
   input wire logic raw_bit_i,
   input wire logic raw_valid_i,
   input wire logic rd_i,
   output logic [15:0] rnd_data_o,
   output logic rnd_valid_o,
   output logic error_o,
   output logic ready_o
);
   rng_gate_pkg::gate_state_t state_ff;
   rng_gate_pkg::gate_state_t nxt_state;
   logic [5:0] run_ff;
   logic last_bit_ff;
   logic [7:0] win_cnt_ff;
   logic [7:0] ones_ff;
   logic win_pass_ff;
   logic total_fail;
   logic stat_fail;
   logic rep_fail;
   logic [8:0] seed_cnt_ff;
   logic [`RNG_STATE_W-1:0] drg_ff;
   logic [15:0] acc_ff;
   logic [4:0] acc_cnt_ff;
   logic [4:0] credit_ff;
   logic [15:0] prev_ff;
   logic prev_ok_ff;
   logic word_done;
   logic [15:0] word_val;
   logic buf_in_ready;
   logic [15:0] buf_data;
   logic buf_valid;
   logic take;
   logic fail_any;
   logic in_bit;
   logic [4:0] word_bits;

   assign word_bits = word16_i ? 5'h10 : 5'h08;
   // Raw bit enters the word only from the tested path
   assign in_bit = raw_valid_i && (state_ff != rng_gate_pkg::ST_FAILED);

   // Stuck source: long run of equal bits counts as total failure
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) begin
         run_ff <= 6'h00;
         last_bit_ff <= 1'b0;
      end else if (raw_valid_i) begin
         last_bit_ff <= raw_bit_i;
         // Length of the current run, this bit included
         run_ff <= (raw_bit_i == last_bit_ff) ? run_ff + 6'h01 : 6'h01;
      end
   end
   assign total_fail = raw_valid_i && (raw_bit_i == last_bit_ff) && (run_ff >= `RNG_STUCK_LIMIT - 6'h01);

   // Monobit window test runs on every raw bit, never on demand
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) begin
         win_cnt_ff <= 8'h00;
         ones_ff <= 8'h00;
         win_pass_ff <= 1'b0;
      end else if (raw_valid_i) begin
         if (win_cnt_ff == `RNG_WIN_BITS - 8'h01) begin
            win_cnt_ff <= 8'h00;
            ones_ff <= 8'h00;
            win_pass_ff <= !stat_fail;
         end else begin
            win_cnt_ff <= win_cnt_ff + 8'h01;
            ones_ff <= ones_ff + {7'h00, raw_bit_i};
         end
      end
   end
   assign stat_fail = raw_valid_i && (win_cnt_ff == `RNG_WIN_BITS - 8'h01) &&
      ((ones_ff + {7'h00, raw_bit_i} < `RNG_ONES_MIN) || (ones_ff + {7'h00, raw_bit_i} > `RNG_ONES_MAX));

   assign rep_fail = word_done && prev_ok_ff && (word_val == prev_ff);
   assign fail_any = total_fail || stat_fail || rep_fail;

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         rng_gate_pkg::ST_STARTUP: begin
            if (fail_any) begin
               nxt_state = rng_gate_pkg::ST_FAILED;
            end else if (win_pass_ff) begin
               nxt_state = hybrid_generator_mode_i ? rng_gate_pkg::ST_SEEDING : rng_gate_pkg::ST_RUN;
            end
         end
         rng_gate_pkg::ST_SEEDING: begin
            if (fail_any) begin
               nxt_state = rng_gate_pkg::ST_FAILED;
            end else if (seed_cnt_ff == `RNG_SEED_BITS) begin
               nxt_state = rng_gate_pkg::ST_RUN;
            end
         end
         rng_gate_pkg::ST_RUN: begin
            if (fail_any) begin
               nxt_state = rng_gate_pkg::ST_FAILED;
            end
         end
         rng_gate_pkg::ST_FAILED: nxt_state = rng_gate_pkg::ST_FAILED;
         default: nxt_state = rng_gate_pkg::ST_FAILED;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) begin
         state_ff <= rng_gate_pkg::ST_STARTUP;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Seeding absorbs raw bits into the post-processor state
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) begin
         seed_cnt_ff <= 9'h000;
      end else if (state_ff == rng_gate_pkg::ST_SEEDING && in_bit && seed_cnt_ff != `RNG_SEED_BITS) begin
         seed_cnt_ff <= seed_cnt_ff + 9'h001;
      end
   end

   // Nonlinear mixing stand-in for the cryptographic post-processor
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) begin
         drg_ff <= `RNG_DRG_INIT;
      end else if (in_bit && hybrid_generator_mode_i) begin
         drg_ff <= {drg_ff[30:0], drg_ff[31] ^ raw_bit_i} ^
            ({drg_ff[12:0], drg_ff[31:13]} & {drg_ff[6:0], drg_ff[31:7]});
      end
   end

   // Credit counts raw bits consumed; each output bit spends one
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i || state_ff != rng_gate_pkg::ST_RUN) begin
         acc_ff <= 16'h0000;
         acc_cnt_ff <= 5'h00;
         credit_ff <= 5'h00;
      end else if (word_done) begin
         // Bit arriving as the word closes starts the next word, so none slips
         acc_ff <= {15'h0000, in_bit && (hybrid_generator_mode_i ? drg_ff[31] : raw_bit_i)};
         acc_cnt_ff <= {4'h0, in_bit};
         credit_ff <= {4'h0, in_bit};
      end else if (in_bit && buf_in_ready) begin
         acc_ff <= {acc_ff[14:0], hybrid_generator_mode_i ? drg_ff[31] : raw_bit_i};
         acc_cnt_ff <= acc_cnt_ff + 5'h01;
         credit_ff <= credit_ff + 5'h01;
      end
   end
   // Word closes only when credit covers every output bit
   assign word_done = (state_ff == rng_gate_pkg::ST_RUN) && (acc_cnt_ff == word_bits) &&
      (credit_ff >= word_bits) && buf_in_ready && !total_fail && !stat_fail;
   assign word_val = word16_i ? acc_ff : {8'h00, acc_ff[7:0]};

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) begin
         prev_ff <= 16'h0000;
         prev_ok_ff <= 1'b0;
      end else if (word_done) begin
         prev_ff <= word_val;
         prev_ok_ff <= 1'b1;
      end
   end

   // Flush on failure so no word built after it can escape
   word_skid_buf u_buf (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i || restart_i),
      .flush_i(fail_any || state_ff == rng_gate_pkg::ST_FAILED),
      .in_data_i(word_val),
      .in_valid_i(word_done && !rep_fail),
      .in_ready_o(buf_in_ready),
      .out_data_o(buf_data),
      .out_valid_o(buf_valid),
      .out_ready_i(take)
   );

   // Output stage holds word and valid until read
   assign take = buf_valid && (!rnd_valid_o || rd_i) && !fail_any && state_ff == rng_gate_pkg::ST_RUN;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i || fail_any || state_ff == rng_gate_pkg::ST_FAILED) begin
         rnd_valid_o <= 1'b0;
         rnd_data_o <= 16'h0000;
      end else if (take) begin
         rnd_valid_o <= 1'b1;
         rnd_data_o <= buf_data;
      end else if (rd_i && rnd_valid_o) begin
         rnd_valid_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) begin
         error_o <= 1'b0;
         ready_o <= 1'b0;
      end else begin
         if (fail_any) begin
            error_o <= 1'b1;
         end
         ready_o <= (nxt_state == rng_gate_pkg::ST_RUN);
      end
   end
endmodule : rng_health_gate

// *** bench/rng_health_gate_asserts.sv ***
/* Port checker for the random number gate.
 Assumes it is bound to every gate instance. */
`timescale 1ns/10ps
`include "rng_gate_cfg.svh"
module rng_health_gate_asserts (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic restart_i,
   input wire logic hybrid_generator_mode_i,
   input wire logic word16_i,
   input wire logic raw_valid_i,
   input wire logic rd_i,
   input wire logic [15:0] rnd_data_o,
   input wire logic rnd_valid_o,
   input wire logic error_o,
   input wire logic ready_o
);
   logic [8:0] raw_cnt_ff;
   logic [15:0] last_ff;
   logic seen_ff;
   wire logic tests_done = raw_cnt_ff >= (hybrid_generator_mode_i ? {1'b0, `RNG_WIN_BITS} + `RNG_SEED_BITS :
      {1'b0, `RNG_WIN_BITS});
   // Saturates so a long run never wraps
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) raw_cnt_ff <= 9'h000;
      else if (raw_valid_i && raw_cnt_ff != 9'h1FF) raw_cnt_ff <= raw_cnt_ff + 9'h001;
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || restart_i) seen_ff <= 1'b0;
      else if (rd_i && rnd_valid_o) seen_ff <= 1'b1;
   end
   always_ff @(posedge clk_i) begin
      if (rd_i && rnd_valid_o) last_ff <= rnd_data_o;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i || restart_i);
   a_valid_held: assert property (rnd_valid_o && !rd_i |=> rnd_valid_o || error_o)
      else $error("valid lost");
   a_data_held: assert property (rnd_valid_o && !rd_i |=> $stable(rnd_data_o) || error_o)
      else $error("word moved");
   a_error_sticky: assert property (error_o |=> error_o)
      else $error("error cleared");
   a_error_blocks: assert property (error_o |=> !rnd_valid_o && !ready_o)
      else $error("output after failure");
   a_idle_no_word: assert property (!ready_o ##1 !ready_o |-> !rnd_valid_o)
      else $error("word while not ready");
   a_ready_late: assert property ($rose(ready_o) |-> tests_done)
      else $error("ready too early");
   a_byte_upper: assert property (rnd_valid_o && !word16_i |-> rnd_data_o[15:8] == 8'h00)
      else $error("byte upper not zero");
   a_no_repeat: assert property (rnd_valid_o && seen_ff |-> rnd_data_o != last_ff)
      else $error("repeated word");
   c_ready: cover property ($rose(ready_o));
   c_read: cover property (rd_i && rnd_valid_o);
   c_error: cover property ($rose(error_o));
endmodule : rng_health_gate_asserts
bind rng_health_gate rng_health_gate_asserts i_rng_health_gate_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
   .restart_i(restart_i), .hybrid_generator_mode_i(hybrid_generator_mode_i), .word16_i(word16_i),
   .raw_valid_i(raw_valid_i), .rd_i(rd_i), .rnd_data_o(rnd_data_o), .rnd_valid_o(rnd_valid_o),
   .error_o(error_o), .ready_o(ready_o));

// *** bench/word_reader.sv ***
/* Consumer model reading random words.
 Assumes valid is held until read. */
`timescale 1ns/10ps
module word_reader (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [15:0] data_i,
   input wire logic valid_i,
   output logic rd_o,
   output logic [15:0] got_o,
   output int n_o
);
   assign rd_o = valid_i && go_i;
   initial n_o = 0;
   always @(posedge clk_i) begin
      if (rd_o) begin
         got_o <= data_i;
         n_o <= n_o + 1;
      end
   end
endmodule : word_reader

// *** bench/test_rng_health_gate.sv ***
/* Bench for the random number gate.
 Assumes the checker binds itself to the gate. */
`timescale 1ns/10ps
module test_rng_health_gate;
   logic clk_i = 1'b0, sys_rst_i = 1'b1, restart_i = 1'b0, mode = 1'b0, w16 = 1'b0;
   logic raw_bit = 1'b0, raw_valid = 1'b0, go = 1'b0, rd, valid, err, rdy;
   logic [15:0] data, got;
   int n, fail_count = 0, num_checks = 0;
   rng_health_gate i_rng_health_gate (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .restart_i(restart_i),
      .hybrid_generator_mode_i(mode), .word16_i(w16), .raw_bit_i(raw_bit), .raw_valid_i(raw_valid),
      .rd_i(rd), .rnd_data_o(data), .rnd_valid_o(valid), .error_o(err), .ready_o(rdy));
   word_reader i_word_reader (.clk_i(clk_i), .go_i(go), .data_i(data), .valid_i(valid), .rd_o(rd),
      .got_o(got), .n_o(n));
   initial forever #5 clk_i = ~clk_i;
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic hold(ref logic s);
      for (int i = 0; i < 30 && s !== 1'b1; i++)
         @(negedge clk_i);
   endtask : hold
   // Bits go out MSB first, one per cycle
   task automatic feed(input logic [15:0] w);
      for (int i = 15; i >= 0; i--) begin
         @(negedge clk_i);
         raw_bit = w[i];
         raw_valid = 1'b1;
      end
      @(negedge clk_i);
      raw_valid = 1'b0;
   endtask : feed
   task automatic boot(input logic m, input logic w);
      @(negedge clk_i);
      mode = m;
      w16 = w;
      go = 1'b0;
      sys_rst_i = 1'b1;
      repeat (2) @(negedge clk_i);
      sys_rst_i = 1'b0;
      repeat (7) feed(16'hAAAA);
      chk("early ready", 16'h0000, {15'h0000, rdy});
      feed(16'hAAAA);
   endtask : boot
   task automatic t_phys(input logic w);
      boot(1'b0, w);
      hold(rdy);
      chk("ready", 16'h0001, {15'h0000, rdy});
      feed(16'hA55A);
      if (w)
         feed(16'h3CC3);
      hold(valid);
      repeat (5) @(negedge clk_i);
      chk("held word", w ? 16'hA55A : 16'h00A5, data);
      go = 1'b1;
      repeat (9) @(negedge clk_i);
      chk("last word", w ? 16'h3CC3 : 16'h005A, got);
      $display("phys test done");
   endtask : t_phys
   task automatic t_repeat;
      int n0;
      n0 = n;
      feed(16'h5A5A);
      hold(err);
      chk("repeat error", 16'h0001, {15'h0000, err});
      chk("words", n0[15:0], n[15:0]);
      $display("repeat test done");
   endtask : t_repeat
   task automatic t_bad(input logic [15:0] pat, input int reps);
      @(negedge clk_i);
      restart_i = 1'b1;
      repeat (2) @(negedge clk_i);
      restart_i = 1'b0;
      chk("error cleared", 16'h0000, {15'h0000, err});
      repeat (reps) feed(pat);
      hold(err);
      chk("error", 16'h0001, {15'h0000, err});
      chk("ready", 16'h0000, {15'h0000, rdy});
      $display("bad source test done");
   endtask : t_bad
   task automatic t_runfail;
      // 16-bit words, so the stuck run trips before a second word can repeat
      boot(1'b0, 1'b1);
      hold(rdy);
      feed(16'h0000);
      hold(valid);
      chk("word before fail", 16'h0001, {15'h0000, valid});
      repeat (2) feed(16'h0000);
      hold(err);
      chk("run error", 16'h0001, {15'h0000, err});
      chk("valid", 16'h0000, {15'h0000, valid});
      $display("run failure test done");
   endtask : t_runfail
   task automatic t_hybrid;
      int n0;
      boot(1'b1, 1'b1);
      repeat (15) feed(16'hAAAA);
      chk("seed ready", 16'h0000, {15'h0000, rdy});
      feed(16'hAAAA);
      hold(rdy);
      chk("ready", 16'h0001, {15'h0000, rdy});
      n0 = n;
      go = 1'b1;
      feed(16'hA55A);
      repeat (6) @(negedge clk_i);
      chk("hybrid words", n0[15:0] + 16'h0001, n[15:0]);
      $display("hybrid test done");
   endtask : t_hybrid
   task automatic results;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : results
   initial begin
      #200000;
      fail_count++;
      results();
   end
   initial begin
      t_phys(1'b0);
      t_repeat();
      t_bad(16'h0000, 2);
      t_bad(16'h8888, 8);
      t_runfail();
      t_hybrid();
      t_phys(1'b1);
      results();
   end
endmodule : test_rng_health_gate
